// >>> common/ptd_pkg.sv
// Purpose: shared constants for the split bulk/control descriptor path
// Assumes: four 32-bit descriptor words, word 0 holds the valid bit
// Notes:   field positions are bit offsets inside their own word
package ptd_pkg;

  // descriptor words
  localparam int         DW_COUNT  = 4;
  localparam logic [1:0] DW0_IDX   = 2'h0;
  localparam logic [1:0] DW1_IDX   = 2'h1;
  localparam logic [1:0] DW2_IDX   = 2'h2;
  localparam logic [1:0] DW3_IDX   = 2'h3;
  // word 0 fields
  localparam int VALID_BIT = 0;
  localparam int TOTAL_LSB = 3;
  localparam int MPS_LSB   = 18;
  localparam int EP0_BIT   = 31;
  // word 1 fields
  localparam int EPHI_LSB  = 0;
  localparam int FUNC_LSB  = 3;
  localparam int TOKEN_LSB = 10;
  localparam int KIND_LSB  = 12;
  localparam int SPLIT_BIT = 14;
  localparam int SPEED_LSB = 16;
  localparam int PORT_LSB  = 18;
  localparam int HUB_LSB   = 25;
  // word 2 fields
  localparam int PTR_LSB   = 8;
  localparam int RL_LSB    = 25;
  // word 3 fields
  localparam int DONE_LSB  = 0;
  localparam int NAK_LSB   = 19;
  localparam int CERR_LSB  = 23;
  // bits that carry meaning; the rest are reserved
  localparam logic [31:0] DW0_USED = 32'h9FFF_FFF9;
  localparam logic [31:0] DW1_USED = 32'hFFFF_7FFF;
  localparam logic [31:0] DW2_USED = 32'h1EFF_FF00;
  localparam logic [31:0] DW3_USED = 32'h01F8_7FFF;
  // buffer memory window and pointer granule
  localparam logic [31:0] BUF_BASE  = 32'h0000_0400;
  localparam int          PTR_SHIFT = 3;
  // packet and counter limits
  localparam logic [10:0] FS_MAX_PACKET = 11'h040;
  localparam logic [1:0]  CERR_INIT     = 2'h3;
  // software register offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_DW0      = 8'h04;
  localparam logic [7:0] REG_DW1      = 8'h08;
  localparam logic [7:0] REG_DW2      = 8'h0C;
  localparam logic [7:0] REG_BUFADDR  = 8'h10;
  localparam logic [7:0] REG_STATUS   = 8'h14;
  localparam logic [7:0] REG_IRQ_STAT = 8'h18;
  localparam logic [7:0] REG_IRQ_MASK = 8'h1C;
  localparam logic [7:0] REG_RESULT   = 8'h20;
  // interrupt status bits
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_FAIL_BIT = 1;

  typedef enum logic [1:0] {
    TOK_OUT   = 2'b00,
    TOK_IN    = 2'b01,
    TOK_SETUP = 2'b10
  } token_t;

  typedef enum logic [1:0] {
    KIND_CTRL = 2'b00,
    KIND_BULK = 2'b10
  } kind_t;

  typedef enum logic [1:0] {
    SE_FULL = 2'b00,
    SE_LOW  = 2'b10
  } speed_t;

  typedef enum logic [1:0] {
    RSP_ACK  = 2'b00,
    RSP_NAK  = 2'b01,
    RSP_NYET = 2'b10,
    RSP_ERR  = 2'b11
  } rsp_t;

endpackage : ptd_pkg

// >>> common/ptd_if.sv
// Purpose: link between software register front end and descriptor engine
// Assumes: both ends on one clock
// Notes:   word writes are single-cycle strobes
`timescale 1ns/10ps
`default_nettype none
interface ptd_if (
  input wire logic clk
);
  logic        ptd_wr;     // write strobe for one descriptor word
  logic [1:0]  ptd_idx;    // word index
  logic [31:0] ptd_wdata;  // word value
  logic        ptd_active; // descriptor valid bit
  logic        ptd_done;   // pulse: descriptor completed normally
  logic        ptd_fail;   // pulse: descriptor ended by error or retries
  logic [31:0] ptd_result; // written-back word 3

  modport controller (
    input  ptd_wr, ptd_idx, ptd_wdata,
    output ptd_active, ptd_done, ptd_fail, ptd_result
  );

  modport software (
    output ptd_wr, ptd_idx, ptd_wdata,
    input  ptd_active, ptd_done, ptd_fail, ptd_result
  );
endinterface : ptd_if
`default_nettype wire

// >>> core/split_desc_engine.sv
// Purpose: executes one split bulk/control descriptor and writes it back
// Assumes: token and response ports are logic on the same clock
// Notes:   descriptor writes are ignored while a descriptor runs
//
// How it works
// R1: write back bytes actually moved
// R2: zero reload disables nak counting
// R3: software loads nak counter equal reload
// R4: software zeroes reload for split
// R5: pointer is buffer address, 8-byte granule
// R6: route split by hub and port
// R7: speed code 10 low, 00 full
// R8: split bit picks translator or direct
// R9: kind 00 control, 10 bulk
// R10: token 00 out, 01 in, 10 setup
// R11: target function by device address
// R12: endpoint number joined across two words
// R13: packet length bounded by max packet
// R14: total count bounds the buffer
// R15: software sets valid when data ready
// R16: clear valid at end or fatal error
// R17: clear valid when nak counter empties
// R18: error counter drains, nak restores it
// R19: reserved bits ignored
`timescale 1ns/10ps
`default_nettype none
module split_desc_engine
  import ptd_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           rst_n,
  ptd_if.controller           link,
  output var  logic           tok_req,
  output var  token_t         tok_pid,
  output var  logic [6:0]     tok_function,
  output var  logic [3:0]     tok_endpoint,
  output var  logic           tok_split,
  output var  logic [6:0]     tok_hub,
  output var  logic [6:0]     tok_port,
  output var  logic           tok_low_speed,
  output var  logic           tok_bulk,
  output var  logic [18:0]    tok_mem_addr,
  output var  logic [10:0]    tok_len,
  input  wire logic           rsp_valid,
  input  wire rsp_t           rsp_code,
  input  wire logic [10:0]    rsp_bytes
);

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT  = 2'b10,
    ST_CLOSE = 2'b11
  } state_t;

  logic [31:0] mem_reg  [DW_COUNT];  // descriptor words
  logic [31:0] mem_next [DW_COUNT];
  state_t      state_reg, state_next;  // sequencer
  logic [14:0] count_reg, count_next;  // bytes moved so far
  logic [3:0]  nak_reg,   nak_next;    // live nak counter
  logic [1:0]  cerr_reg,  cerr_next;   // live error counter
  logic        fail_reg,  fail_next;   // ending was not normal
  logic        done_reg,  done_next;   // completion pulses
  logic        flt_reg,   flt_next;
  logic        req_next;
  token_t      pid_next;
  logic [6:0]  func_next, hub_next, port_next;
  logic [3:0]  ep_next;
  logic        split_next, low_next, bulk_next;
  logic [18:0] addr_next;
  logic [10:0] len_next;

  // descriptor fields as stored
  logic [10:0] mps;
  logic [14:0] total;
  logic [15:0] ptr;
  logic [3:0]  reload;
  logic [14:0] remain;
  logic [15:0] moved;

  // r19 reserved bits are never looked at
  always_comb begin
    mps    = mem_reg[DW0_IDX][MPS_LSB +: 11];
    total  = mem_reg[DW0_IDX][TOTAL_LSB +: 15];
    ptr    = mem_reg[DW2_IDX][PTR_LSB +: 16];
    reload = mem_reg[DW2_IDX][RL_LSB +: 4];
    remain = total - count_reg;
    moved  = {1'b0, count_reg} + {5'h00, rsp_bytes};
  end

  // next-state and datapath
  always_comb begin
    for (int i = 0; i < DW_COUNT; i++) begin
      mem_next[i] = mem_reg[i];
    end
    state_next = state_reg;
    count_next = count_reg;
    nak_next   = nak_reg;
    cerr_next  = cerr_reg;
    fail_next  = fail_reg;
    done_next  = 1'b0;
    flt_next   = 1'b0;
    req_next   = tok_req;
    pid_next   = tok_pid;
    func_next  = tok_function;
    ep_next    = tok_endpoint;
    split_next = tok_split;
    hub_next   = tok_hub;
    port_next  = tok_port;
    low_next   = tok_low_speed;
    bulk_next  = tok_bulk;
    addr_next  = tok_mem_addr;
    len_next   = tok_len;
    unique case (state_reg)
      ST_IDLE: begin
        // words are only taken while nothing runs
        if (link.ptd_wr) begin
          mem_next[link.ptd_idx] = link.ptd_wdata;
        end
        // r15 software arms the descriptor
        if (mem_reg[DW0_IDX][VALID_BIT]) begin
          // r10 token selects pid
          pid_next   = token_t'(mem_reg[DW1_IDX][TOKEN_LSB +: 2]);
          // r11 target function address
          func_next  = mem_reg[DW1_IDX][FUNC_LSB +: 7];
          // r12 endpoint reassembled
          ep_next    = {mem_reg[DW1_IDX][EPHI_LSB +: 3],
                        mem_reg[DW0_IDX][EP0_BIT]};
          // r8 split or direct
          split_next = mem_reg[DW1_IDX][SPLIT_BIT];
          // r6 hub routing
          hub_next   = mem_reg[DW1_IDX][HUB_LSB +: 7];
          port_next  = mem_reg[DW1_IDX][PORT_LSB +: 7];
          // r7 speed only for split
          low_next   = mem_reg[DW1_IDX][SPLIT_BIT] &&
                       (mem_reg[DW1_IDX][SPEED_LSB +: 2] == SE_LOW);
          // r9 endpoint kind decode
          bulk_next  = (mem_reg[DW1_IDX][KIND_LSB +: 2] == KIND_BULK);
          count_next = '0;
          nak_next   = mem_reg[DW3_IDX][NAK_LSB +: 4];
          cerr_next  = mem_reg[DW3_IDX][CERR_LSB +: 2];
          fail_next  = 1'b0;
          state_next = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        // r5 pointer scaled to bytes
        addr_next  = {ptr, 3'h0} + {4'h0, count_reg};
        // r13 packet bounded by max packet
        // r14 and by what is left of the buffer
        if ({4'h0, mps} < remain) begin
          len_next = mps;
        end else begin
          len_next = remain[10:0];
        end
        req_next   = 1'b1;
        state_next = ST_WAIT;
      end
      ST_WAIT: begin
        if (rsp_valid) begin
          req_next   = 1'b0;
          state_next = ST_ISSUE;
          unique case (rsp_code)
            RSP_ACK: begin
              // r1 count real bytes
              count_next = moved[14:0];
              // short packet or full buffer ends it
              if (rsp_bytes < tok_len || moved >= {1'b0, total}) begin
                state_next = ST_CLOSE;
              end
            end
            RSP_NAK: begin
              // r18 nak restores error counter
              cerr_next = mem_reg[DW3_IDX][CERR_LSB +: 2];
              // r2 zero reload: no counting
              if (reload != 4'h0) begin
                nak_next = nak_reg - 4'h1;
                // r17 retries exhausted
                if (nak_reg <= 4'h1) begin
                  nak_next   = 4'h0;
                  fail_next  = 1'b1;
                  state_next = ST_CLOSE;
                end
              end
            end
            RSP_NYET: begin
              // r18 nyet restores error counter
              cerr_next = mem_reg[DW3_IDX][CERR_LSB +: 2];
            end
            RSP_ERR: begin
              // r18 error counter drains
              cerr_next = cerr_reg - 2'h1;
              if (cerr_reg <= 2'h1) begin
                cerr_next  = 2'h0;
                fail_next  = 1'b1;
                state_next = ST_CLOSE;
              end
            end
          endcase
        end
      end
      ST_CLOSE: begin
        // r1 write back transferred count
        mem_next[DW3_IDX][DONE_LSB +: 15] = count_reg;
        mem_next[DW3_IDX][NAK_LSB +: 4]   = nak_reg;
        mem_next[DW3_IDX][CERR_LSB +: 2]  = cerr_reg;
        // r16 descriptor retired
        mem_next[DW0_IDX][VALID_BIT]      = 1'b0;
        done_next  = !fail_reg;
        flt_next   = fail_reg;
        state_next = ST_IDLE;
      end
    endcase
  end

  // register everything
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DW_COUNT; i++) begin
        mem_reg[i] <= 32'h0000_0000;
      end
      state_reg     <= ST_IDLE;
      count_reg     <= '0;
      nak_reg       <= '0;
      cerr_reg      <= '0;
      fail_reg      <= 1'b0;
      done_reg      <= 1'b0;
      flt_reg       <= 1'b0;
      tok_req       <= 1'b0;
      tok_pid       <= TOK_OUT;
      tok_function  <= '0;
      tok_endpoint  <= '0;
      tok_split     <= 1'b0;
      tok_hub       <= '0;
      tok_port      <= '0;
      tok_low_speed <= 1'b0;
      tok_bulk      <= 1'b0;
      tok_mem_addr  <= '0;
      tok_len       <= '0;
    end else begin
      for (int i = 0; i < DW_COUNT; i++) begin
        mem_reg[i] <= mem_next[i];
      end
      state_reg     <= state_next;
      count_reg     <= count_next;
      nak_reg       <= nak_next;
      cerr_reg      <= cerr_next;
      fail_reg      <= fail_next;
      done_reg      <= done_next;
      flt_reg       <= flt_next;
      tok_req       <= req_next;
      tok_pid       <= pid_next;
      tok_function  <= func_next;
      tok_endpoint  <= ep_next;
      tok_split     <= split_next;
      tok_hub       <= hub_next;
      tok_port      <= port_next;
      tok_low_speed <= low_next;
      tok_bulk      <= bulk_next;
      tok_mem_addr  <= addr_next;
      tok_len       <= len_next;
    end
  end

  // status toward software, all from flops
  assign link.ptd_active = mem_reg[DW0_IDX][VALID_BIT];
  assign link.ptd_result = mem_reg[DW3_IDX];
  assign link.ptd_done   = done_reg;
  assign link.ptd_fail   = flt_reg;

endmodule : split_desc_engine
`default_nettype wire

// >>> core/split_desc_front.sv
// Purpose: software register front end that builds and launches descriptors
// Assumes: Avalon-MM master on the same clock
// Notes:   one wait state on every access
`timescale 1ns/10ps
`default_nettype none
module split_desc_front
  import ptd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  output var  logic        irq,
  ptd_if.software          link
);

  logic [31:0] dw0_reg, dw0_next;   // software images
  logic [31:0] dw1_reg, dw1_next;
  logic [31:0] dw2_reg, dw2_next;
  logic [31:0] buf_reg, buf_next;   // processor data address
  logic [1:0]  stat_reg, stat_next; // sticky events
  logic [1:0]  mask_reg, mask_next;
  logic [2:0]  seq_reg, seq_next;   // words left to send
  logic [31:0] rd_next;
  logic        wait_next, irq_next;
  logic        wr_next;
  logic [1:0]  idx_next;
  logic [31:0] wdata_next;
  logic        acc, wr_go;
  logic [15:0] ptr;
  logic [31:0] word;

  // bus decode and next values
  always_comb begin
    dw0_next   = dw0_reg;
    dw1_next   = dw1_reg;
    dw2_next   = dw2_reg;
    buf_next   = buf_reg;
    mask_next  = mask_reg;
    seq_next   = seq_reg;
    rd_next    = avs_readdata;
    acc        = (avs_read || avs_write) && avs_waitrequest;
    wr_go      = avs_write && !avs_waitrequest;
    wait_next  = !acc;
    // r5 processor address to buffer pointer
    ptr        = 16'((buf_reg - BUF_BASE) >> PTR_SHIFT);
    // events win over a clearing write
    stat_next  = stat_reg;
    if (wr_go && avs_address == REG_IRQ_STAT) begin
      stat_next = stat_reg & ~avs_writedata[1:0];
    end
    stat_next[IRQ_DONE_BIT] = stat_next[IRQ_DONE_BIT] | link.ptd_done;
    stat_next[IRQ_FAIL_BIT] = stat_next[IRQ_FAIL_BIT] | link.ptd_fail;
    irq_next   = |(stat_next & mask_reg);
    if (wr_go) begin
      unique case (avs_address)
        REG_DW0:      dw0_next  = avs_writedata;
        REG_DW1:      dw1_next  = avs_writedata;
        REG_DW2:      dw2_next  = avs_writedata;
        REG_BUFADDR:  buf_next  = avs_writedata;
        REG_IRQ_MASK: mask_next = avs_writedata[1:0];
        REG_CTRL: begin
          if (avs_writedata[0] && seq_reg == 3'h0 && !link.ptd_active) begin
            seq_next = 3'h4;
          end
        end
        default: ;
      endcase
    end
    if (acc && avs_read) begin
      unique case (avs_address)
        REG_DW0:      rd_next = dw0_reg;
        REG_DW1:      rd_next = dw1_reg;
        REG_DW2:      rd_next = dw2_reg;
        REG_BUFADDR:  rd_next = buf_reg;
        REG_STATUS:   rd_next = {31'h0, link.ptd_active || seq_reg != 3'h0};
        REG_IRQ_STAT: rd_next = {30'h0, stat_reg};
        REG_IRQ_MASK: rd_next = {30'h0, mask_reg};
        REG_RESULT:   rd_next = link.ptd_result;
        default:      rd_next = 32'h0000_0000;
      endcase
    end
    // words go out 3,2,1,0 so valid lands last
    idx_next   = 2'(seq_reg - 3'h1);
    wr_next    = (seq_reg != 3'h0);
    word       = 32'h0000_0000;
    unique case (idx_next)
      DW3_IDX: begin
        // r3 nak counter equals reload, zero for split
        word[NAK_LSB +: 4] = dw1_reg[SPLIT_BIT] ? 4'h0 : dw2_reg[RL_LSB +: 4];
        word[CERR_LSB +: 2] = CERR_INIT;
      end
      DW2_IDX: begin
        word = dw2_reg & DW2_USED;
        word[PTR_LSB +: 16] = ptr;
        // r4 reload zero for split
        if (dw1_reg[SPLIT_BIT]) begin
          word[RL_LSB +: 4] = 4'h0;
        end
      end
      DW1_IDX: word = dw1_reg & DW1_USED;
      DW0_IDX: begin
        // r19 reserved bits sent as zero
        word = dw0_reg & DW0_USED;
        // r13 full/low speed capped
        if (dw1_reg[SPLIT_BIT] && word[MPS_LSB +: 11] > FS_MAX_PACKET) begin
          word[MPS_LSB +: 11] = FS_MAX_PACKET;
        end
        // r15 valid set with the last word
        word[VALID_BIT] = 1'b1;
      end
    endcase
    wdata_next = word;
    if (seq_reg != 3'h0) begin
      seq_next = seq_reg - 3'h1;
    end
  end

  // register everything
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dw0_reg         <= '0;
      dw1_reg         <= '0;
      dw2_reg         <= '0;
      buf_reg         <= BUF_BASE;
      stat_reg        <= '0;
      mask_reg        <= '0;
      seq_reg         <= '0;
      avs_readdata    <= '0;
      avs_waitrequest <= 1'b1;
      irq             <= 1'b0;
      link.ptd_wr     <= 1'b0;
      link.ptd_idx    <= '0;
      link.ptd_wdata  <= '0;
    end else begin
      dw0_reg         <= dw0_next;
      dw1_reg         <= dw1_next;
      dw2_reg         <= dw2_next;
      buf_reg         <= buf_next;
      stat_reg        <= stat_next;
      mask_reg        <= mask_next;
      seq_reg         <= seq_next;
      avs_readdata    <= rd_next;
      avs_waitrequest <= wait_next;
      irq             <= irq_next;
      link.ptd_wr     <= wr_next;
      link.ptd_idx    <= idx_next;
      link.ptd_wdata  <= wdata_next;
    end
  end

endmodule : split_desc_front
`default_nettype wire

// >>> tb/ptd_link_asserts.sv
// Purpose: checks on the link between front end and descriptor engine
// Assumes: one clock, asynchronous active-low reset
// Notes:   sees only the link signals
`timescale 1ns/10ps
`default_nettype none
module ptd_link_asserts
  import ptd_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ptd_wr,
  input wire logic [1:0]  ptd_idx,
  input wire logic [31:0] ptd_wdata,
  input wire logic        ptd_active,
  input wire logic        ptd_done,
  input wire logic        ptd_fail,
  input wire logic [31:0] ptd_result
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic        w0, w1, w2, w3; // word strobes by index
  logic [14:0] total_reg;      // length of the running descriptor
  logic [14:0] total_next;
  logic [31:0] used;           // meaningful bits of the word sent
  assign w0 = ptd_wr && ptd_idx == DW0_IDX;
  assign w1 = ptd_wr && ptd_idx == DW1_IDX;
  assign w2 = ptd_wr && ptd_idx == DW2_IDX;
  assign w3 = ptd_wr && ptd_idx == DW3_IDX;
  // next length and reserved map
  always_comb begin
    total_next = w0 ? ptd_wdata[TOTAL_LSB+:15] : total_reg;
    case (ptd_idx)
      DW0_IDX: used = DW0_USED;
      DW1_IDX: used = DW1_USED;
      DW2_IDX: used = DW2_USED;
      default: used = DW3_USED;
    endcase
  end
  // length register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      total_reg <= '0;
    end else begin
      total_reg <= total_next;
    end
  end
  sequence s_rest; w2 ##1 w1 ##1 w0; endsequence
  sequence s_split_w1; w1 && ptd_wdata[SPLIT_BIT]; endsequence
  chk_word_order: assert property (w3 |=> s_rest)
    else $error("descriptor words out of order");
  chk_valid_sent: assert property (w0 |-> ptd_wdata[VALID_BIT])
    else $error("word 0 sent without valid");
  chk_active_rises: assert property (w0 |=> ptd_active)
    else $error("engine did not take valid");
  chk_end_clears: assert property ((ptd_done || ptd_fail) |-> !ptd_active)
    else $error("valid still set at end");
  chk_valid_drop: assert property ($fell(ptd_active) |-> ptd_done || ptd_fail)
    else $error("valid dropped without end pulse");
  chk_split_reload: assert property (
    (w2 && ptd_wdata[RL_LSB+:4] != 4'h0) ##1 w1 |-> !ptd_wdata[SPLIT_BIT])
    else $error("split with nonzero reload");
  chk_split_cap: assert property (
    s_split_w1 ##1 w0 |-> ptd_wdata[MPS_LSB+:11] <= FS_MAX_PACKET)
    else $error("split packet over cap");
  chk_nak_reload: assert property (
    w3 ##1 w2 |-> ptd_wdata[RL_LSB+:4] == $past(ptd_wdata[NAK_LSB+:4]))
    else $error("nak counter differs from reload");
  chk_err_init: assert property (w3 |-> ptd_wdata[CERR_LSB+:2] == CERR_INIT)
    else $error("error counter not full");
  chk_reserved_zero: assert property (ptd_wr |-> (ptd_wdata & ~used) == '0)
    else $error("reserved bits sent");
  chk_count_bound: assert property (ptd_done |-> ptd_result[14:0] <= total_reg)
    else $error("done count above length");
endmodule : ptd_link_asserts
`default_nettype wire

// >>> tb/bulk_split_descriptor_decode_test.sv
// Purpose: front end and engine joined, driven over the register bus
// Assumes: bench answers tokens in place of the far side
// Notes:   random descriptors plus nak, error and short cases
`timescale 1ns/10ps
`default_nettype none
module bulk_split_descriptor_decode_test
  import ptd_pkg::*;
;
  logic        clk, rst_n, avs_read, avs_write, irq, rsp_valid;
  logic        avs_waitrequest, tok_req, tok_split, tok_low_speed, tok_bulk;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, d0, d1, d2;
  token_t      tok_pid;
  rsp_t        rsp_code;
  logic [6:0]  tok_function, tok_hub, tok_port;
  logic [3:0]  tok_endpoint;
  logic [18:0] tok_mem_addr;
  logic [10:0] tok_len, rsp_bytes;
  logic [14:0] done_b;   // bytes acknowledged so far
  logic [1:0]  mask_v;   // interrupt mask in force
  int          error_cnt, n_checks, ptr;
  logic [7:0]  ra [5] = '{REG_STATUS, REG_IRQ_STAT, REG_IRQ_MASK,
                          REG_BUFADDR, 8'h24};
  logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h0, BUF_BASE, 32'h0};
  always #2 clk = ~clk;
  ptd_if ptd_if_inst (.clk(clk));
  split_desc_front split_desc_front_inst (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .link(ptd_if_inst));
  split_desc_engine split_desc_engine_inst (.clk(clk), .rst_n(rst_n),
    .link(ptd_if_inst), .tok_req(tok_req), .tok_pid(tok_pid),
    .tok_function(tok_function), .tok_endpoint(tok_endpoint),
    .tok_split(tok_split), .tok_hub(tok_hub), .tok_port(tok_port),
    .tok_low_speed(tok_low_speed), .tok_bulk(tok_bulk),
    .tok_mem_addr(tok_mem_addr), .tok_len(tok_len),
    .rsp_valid(rsp_valid), .rsp_code(rsp_code), .rsp_bytes(rsp_bytes));
  ptd_link_asserts ptd_link_asserts_inst (.clk(clk), .rst_n(rst_n),
    .ptd_wr(ptd_if_inst.ptd_wr), .ptd_idx(ptd_if_inst.ptd_idx),
    .ptd_wdata(ptd_if_inst.ptd_wdata), .ptd_active(ptd_if_inst.ptd_active),
    .ptd_done(ptd_if_inst.ptd_done), .ptd_fail(ptd_if_inst.ptd_fail),
    .ptd_result(ptd_if_inst.ptd_result));
  // verdict and end of run
  task automatic tally_and_finish();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  // one comparison
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("unexpected %0t %s", $time, msg);
    end
  endtask : chk
  // one bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 40) begin
      chk(1'b0, "bus timeout");
      tally_and_finish();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  // bytes the next packet should carry
  function automatic logic [10:0] exp_len();
    logic [14:0] left;
    logic [10:0] m;
    left = d0[TOTAL_LSB+:15] - done_b;
    m = d0[MPS_LSB+:11];
    if (d1[SPLIT_BIT] && m > FS_MAX_PACKET) m = FS_MAX_PACKET;
    return (15'(m) < left) ? m : left[10:0];
  endfunction : exp_len
  // load words, pointer and go
  task automatic launch(input logic [31:0] a, b, c, input int k);
    d0 = a;
    d1 = b;
    d2 = c;
    ptr = k;
    done_b = '0;
    bus(1'b1, REG_DW0, a);
    bus(1'b1, REG_DW1, b);
    bus(1'b1, REG_DW2, c);
    bus(1'b1, REG_BUFADDR, BUF_BASE + 32'(k) * 8);
    bus(1'b1, REG_CTRL, 32'h1);
  endtask : launch
  // wait for a token, check it, answer it
  task automatic answer(input rsp_t c, input logic [10:0] b);
    int i;
    for (i = 0; i < 60; i++) begin
      @(negedge clk);
      if (tok_req === 1'b1) break;
    end
    if (i == 60) begin
      chk(1'b0, "no token");
      tally_and_finish();
    end
    chk(tok_pid === token_t'(d1[TOKEN_LSB+:2]), "pid");
    chk(tok_bulk === (d1[KIND_LSB+:2] == 2'b10), "kind");
    chk(tok_function === d1[FUNC_LSB+:7], "function");
    chk(tok_endpoint === {d1[EPHI_LSB+:3], d0[EP0_BIT]}, "endpoint");
    chk(tok_split === d1[SPLIT_BIT], "split");
    chk(!d1[SPLIT_BIT] || {tok_hub, tok_port} ===
        {d1[HUB_LSB+:7], d1[PORT_LSB+:7]}, "route");
    chk(tok_low_speed === (d1[SPLIT_BIT] && d1[SPEED_LSB+:2] == 2'b10),
        "speed");
    chk(tok_mem_addr === 19'(ptr * 8) + 19'(done_b), "address");
    chk(tok_len === exp_len(), "length");
    @(posedge clk);
    rsp_valid <= 1'b1;
    rsp_code <= c;
    rsp_bytes <= b;
    @(posedge clk);
    rsp_valid <= 1'b0;
    if (c == RSP_ACK) done_b += 15'(b);
  endtask : answer
  // idle wait, then result, status and interrupt
  task automatic finish_desc(input logic [1:0] st);
    int i;
    for (i = 0; i < 30; i++) begin
      bus(1'b0, REG_STATUS, '0);
      if (rd[0] === 1'b0) break;
    end
    chk(i < 30, "still busy");
    if (i == 30) tally_and_finish();
    bus(1'b0, REG_RESULT, '0);
    chk(rd[14:0] === done_b, "byte count");
    bus(1'b0, REG_IRQ_STAT, '0);
    chk(rd[1:0] === st, "end status");
    chk(irq === |(st & mask_v), "irq level");
    bus(1'b1, REG_IRQ_STAT, 32'(st));
    bus(1'b0, REG_IRQ_STAT, '0);
    chk(rd[1:0] === 2'b00 && irq === 1'b0, "clear");
  endtask : finish_desc
  // main sequence
  initial begin
    int n;
    logic sp;
    {clk, rst_n, avs_read, avs_write, rsp_valid} = '0;
    {avs_address, avs_writedata, rsp_bytes} = '0;
    rsp_code = RSP_ACK;
    {error_cnt, n_checks} = '0;
    void'($urandom(99921));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ra[i]) begin
      bus(1'b0, ra[i], '0);
      chk(rd === rv[i], "reset value");
    end
    mask_v = 2'h3;
    bus(1'b1, REG_IRQ_MASK, 32'h3);
    for (n = 0; n < 6; n++) begin
      sp = 1'($urandom);
      launch({1'($urandom), 2'h3, 11'($urandom_range(8, 100)),
              15'($urandom_range(1, 200)), 3'h1},
             {14'($urandom), 2'((n / 2) % 2 * 2), 1'b1, sp,
              2'(n % 2 * 2), 2'(n % 3), 10'($urandom)},
             {3'h7, 4'($urandom), 1'b1, 16'($urandom), 8'hFF},
             $urandom_range(0, 2000));
      while (done_b < d0[TOTAL_LSB+:15]) answer(RSP_ACK, exp_len());
      finish_desc(2'h1);
    end
    // short packet closes early
    launch(32'h0080_0321, 32'h0000_2029, 32'h0, 5);
    answer(RSP_ACK, 11'h020);
    answer(RSP_ACK, 11'h005);
    finish_desc(2'h1);
    // nak counter runs out
    launch(32'h8080_0201, 32'h0000_2429, 32'h0600_0000, 9);
    repeat (3) answer(RSP_NAK, 11'h0);
    finish_desc(2'h2);
    // split forces zero reload, naks are not counted
    launch(32'h8080_0201, 32'h060A_4429, 32'h1E00_0000, 3);
    repeat (5) answer(RSP_NAK, 11'h0);
    while (done_b < d0[TOTAL_LSB+:15]) answer(RSP_ACK, exp_len());
    finish_desc(2'h1);
    // errors drain, nak restores, fail masked
    mask_v = 2'h1;
    bus(1'b1, REG_IRQ_MASK, 32'h1);
    launch(32'h8080_0201, 32'h0000_0829, 32'h0, 1);
    answer(RSP_ERR, 11'h0);
    answer(RSP_NAK, 11'h0);
    answer(RSP_ERR, 11'h0);
    answer(RSP_NYET, 11'h0);
    repeat (3) answer(RSP_ERR, 11'h0);
    finish_desc(2'h2);
    tally_and_finish();
  end
endmodule : bulk_split_descriptor_decode_test
`default_nettype wire
